// *** pkg/pcsia_pkg.sv ***
package pcsia_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PC_W = 10;
    localparam int STK_W = 12;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [9:0] PC_RESET = 10'h3ff;
    localparam logic [7:0] STATUS_RESET = 8'h18;
    localparam logic [7:0] PTR_RESET = 8'hc0;

    // ----------------------------------------------------------------
    // Field positions and masks
    // ----------------------------------------------------------------
    localparam int PAGE_BIT = 5;
    localparam int PTR_BANK_BIT = 5;
    localparam logic [7:0] STATUS_WMASK = 8'hbf;
    localparam logic [7:0] PTR_FIXED_ONES = 8'hc0;

    // ----------------------------------------------------------------
    // Data file addresses seen by the decoder
    // ----------------------------------------------------------------
    localparam logic [4:0] FA_INDIRECT = 5'h00;
    localparam logic [4:0] FA_PC_LOW = 5'h02;
    localparam logic [4:0] FA_STATUS = 5'h03;
    localparam logic [4:0] FA_PTR = 5'h04;

    // ----------------------------------------------------------------
    // Avalon register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_PTR = 3'h4;
    localparam logic [2:0] REG_PC = 3'h5;
    localparam logic [2:0] REG_STK1 = 3'h6;
    localparam logic [2:0] REG_STK2 = 3'h7;

    // ----------------------------------------------------------------
    // Target of a data file access
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TGT_RAM,
        TGT_ZERO,
        TGT_PC_LOW,
        TGT_STATUS,
        TGT_PTR
    } pcsia_tgt_t;

endpackage : pcsia_pkg

// *** rtl/pcsia_stack.sv ***
module pcsia_stack
    import pcsia_pkg::*;
(
    input wire logic clock,
    input wire logic push,
    input wire logic pop,
    input wire logic [11:0] push_data,
    output logic [11:0] level1,
    output logic [11:0] level2
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [11:0] lvl1;
        logic [11:0] lvl2;
    } pcsia_stack_t;

    pcsia_stack_t s_reg;
    pcsia_stack_t s_next;

    always_comb
    begin
        s_next = s_reg;
        if (push)
        begin
            s_next.lvl2 = s_reg.lvl1;
            s_next.lvl1 = push_data;
        end
        else if (pop)
        begin
            s_next.lvl1 = s_reg.lvl2;
        end
    end

    // No reset on purpose: return addresses survive any reset
    always_ff @(posedge clock)
    begin
        s_reg <= s_next;
    end

    assign level1 = s_reg.lvl1;
    assign level2 = s_reg.lvl2;

endmodule : pcsia_stack

// *** rtl/pcsia_core.sv ***
// Operation
// - PC advances by one each instruction
// - Jump loads PC bits 8:0 from instruction
// - Page bit supplies PC bit 9 on jump and call
// - Low PC latch maps onto PC 7:0
// - Call or latch write clears PC bit 8
// - Latch-target move, add, set modify PC
// - Reset points PC at last location
// - After reset instruction PC wraps to zero
// - Reset clears page select bit
// - Two-entry, 12-bit return stack
// - Call shifts level one down, pushes PC+1
// - Return pops PC, loads literal into W
// - Level two kept on every return
// - Reset leaves stack entries unchanged
// - No overflow or underflow flag exists
// - Indirect port accesses pointed data register
// - Indirect read with zero pointer gives 00h
// - Indirect write to the port stores nothing
// - Pointer bits 4:0 pick location 00h-1Fh
// - Pointer bit 5 picks data bank
// - Pointer bits 7:6 read as ones
module pcsia_core
    import pcsia_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic instr_valid,
    input wire logic op_jump,
    input wire logic op_call,
    input wire logic return_with_literal_op,
    input wire logic [11:0] instr_word,
    input wire logic file_rd,
    input wire logic file_wr,
    input wire logic [4:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic [7:0] ram_rdata,
    output logic [9:0] pc,
    output logic w_load,
    output logic [7:0] w_data,
    output logic [5:0] ram_addr,
    output logic ram_rd,
    output logic ram_wr,
    output logic [7:0] ram_wdata,
    output logic [7:0] file_rdata,
    output logic file_rvalid,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [9:0] pc;
        logic [7:0] status;
        logic [7:0] ptr;
        logic w_load;
        logic [7:0] w_data;
        logic [5:0] ram_addr;
        logic ram_rd;
        logic ram_wr;
        logic [7:0] ram_wdata;
        pcsia_tgt_t rd_tgt;
        logic rd_pend;
        logic [7:0] rd_fix;
        logic [7:0] file_rdata;
        logic file_rvalid;
        logic av_wait;
        logic [31:0] av_rdata;
    } pcsia_core_t;

    localparam pcsia_core_t CORE_RESET = '{
        pc: PC_RESET,
        status: STATUS_RESET,
        ptr: PTR_RESET,
        rd_tgt: TGT_RAM,
        av_wait: 1'b1,
        default: '0
    };

    pcsia_core_t s_reg;
    pcsia_core_t s_next;

    logic [11:0] stk_top;
    logic [11:0] stk_second;
    logic stk_push;
    logic stk_pop;
    logic branch;
    logic pc_low_wr;
    logic page;
    pcsia_tgt_t rd_tgt;
    pcsia_tgt_t wr_tgt;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic pcsia_tgt_t tgt_of(input logic [4:0] addr,
                                          input logic [7:0] ptr);
        logic [4:0] a;
        a = addr;
        tgt_of = TGT_RAM;
        if (addr == FA_INDIRECT)
        begin
            a = ptr[4:0];
        end
        if (a == FA_INDIRECT)
        begin
            tgt_of = TGT_ZERO;
        end
        else if (a == FA_PC_LOW)
        begin
            tgt_of = TGT_PC_LOW;
        end
        else if (a == FA_STATUS)
        begin
            tgt_of = TGT_STATUS;
        end
        else if (a == FA_PTR)
        begin
            tgt_of = TGT_PTR;
        end
    endfunction : tgt_of

    function automatic logic [5:0] ram_of(input logic [4:0] addr,
                                          input logic [7:0] ptr);
        // Direct accesses stay in bank 0
        if (addr == FA_INDIRECT)
        begin
            ram_of = {ptr[PTR_BANK_BIT], ptr[4:0]};
        end
        else
        begin
            ram_of = {1'b0, addr};
        end
    endfunction : ram_of

    assign rd_tgt = tgt_of(file_addr, s_reg.ptr);
    assign wr_tgt = tgt_of(file_addr, s_reg.ptr);
    assign branch = instr_valid
        && (op_jump || op_call || return_with_literal_op);
    assign pc_low_wr = file_wr && (wr_tgt == TGT_PC_LOW);
    assign page = s_reg.status[PAGE_BIT];
    assign stk_push = instr_valid && op_call && !op_jump;
    assign stk_pop = instr_valid && return_with_literal_op
        && !op_jump && !op_call;

    // ----------------------------------------------------------------
    // Return stack
    // ----------------------------------------------------------------
    pcsia_stack u_stack (
        .clock(clock),
        .push(stk_push),
        .pop(stk_pop),
        .push_data({2'b00, 10'(s_reg.pc + 10'h001)}),
        .level1(stk_top),
        .level2(stk_second)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        s_next.w_load = 1'b0;
        s_next.ram_rd = 1'b0;
        s_next.ram_wr = 1'b0;
        s_next.file_rvalid = 1'b0;
        s_next.av_wait = 1'b1;
        s_next.rd_pend = file_rd;
        s_next.rd_tgt = rd_tgt;

        // Program counter; branches beat a latch write in the same cycle
        if (instr_valid && op_jump)
        begin
            s_next.pc = {page, instr_word[8:0]};
        end
        else if (instr_valid && op_call)
        begin
            s_next.pc = {page, 1'b0, instr_word[7:0]};
        end
        else if (stk_pop)
        begin
            s_next.pc = stk_top[9:0];
            s_next.w_load = 1'b1;
            s_next.w_data = instr_word[7:0];
        end
        else if (pc_low_wr)
        begin
            s_next.pc = {page, 1'b0, file_wdata};
        end
        else if (instr_valid)
        begin
            s_next.pc = 10'(s_reg.pc + 10'h001);
        end

        // Data file writes
        if (file_wr)
        begin
            case (wr_tgt)
                TGT_STATUS: s_next.status = file_wdata & STATUS_WMASK;
                TGT_PTR: s_next.ptr = file_wdata | PTR_FIXED_ONES;
                TGT_RAM:
                begin
                    s_next.ram_wr = 1'b1;
                    s_next.ram_addr = ram_of(file_addr, s_reg.ptr);
                    s_next.ram_wdata = file_wdata;
                end
                default: s_next.ram_wr = 1'b0;
            endcase
        end

        // Data file reads: issue, then answer one cycle later
        if (file_rd)
        begin
            case (rd_tgt)
                TGT_RAM:
                begin
                    s_next.ram_rd = 1'b1;
                    s_next.ram_addr = ram_of(file_addr, s_reg.ptr);
                end
                TGT_PC_LOW: s_next.rd_fix = s_reg.pc[7:0];
                TGT_STATUS: s_next.rd_fix = s_reg.status;
                TGT_PTR: s_next.rd_fix = s_reg.ptr | PTR_FIXED_ONES;
                default: s_next.rd_fix = 8'h00;
            endcase
        end
        if (s_reg.rd_pend)
        begin
            s_next.file_rvalid = 1'b1;
            if (s_reg.rd_tgt == TGT_RAM)
            begin
                s_next.file_rdata = ram_rdata;
            end
            else
            begin
                s_next.file_rdata = s_reg.rd_fix;
            end
        end

        // Avalon slave: one wait cycle, write lands when wait drops
        if ((avs_read || avs_write) && s_reg.av_wait)
        begin
            s_next.av_wait = 1'b0;
            case (avs_address)
                REG_STATUS: s_next.av_rdata = {24'h000000, s_reg.status};
                REG_PTR: s_next.av_rdata = {24'h000000, s_reg.ptr};
                REG_PC: s_next.av_rdata = {22'h0, s_reg.pc};
                REG_STK1: s_next.av_rdata = {20'h00000, stk_top};
                REG_STK2: s_next.av_rdata = {20'h00000, stk_second};
                default: s_next.av_rdata = 32'h00000000;
            endcase
        end
        // Software wins over a data file write in the same cycle
        if (avs_write && !s_reg.av_wait)
        begin
            if (avs_address == REG_STATUS)
            begin
                s_next.status = avs_writedata[7:0] & STATUS_WMASK;
            end
            else if (avs_address == REG_PTR)
            begin
                s_next.ptr = avs_writedata[7:0] | PTR_FIXED_ONES;
            end
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_reg <= CORE_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign pc = s_reg.pc;
    assign w_load = s_reg.w_load;
    assign w_data = s_reg.w_data;
    assign ram_addr = s_reg.ram_addr;
    assign ram_rd = s_reg.ram_rd;
    assign ram_wr = s_reg.ram_wr;
    assign ram_wdata = s_reg.ram_wdata;
    assign file_rdata = s_reg.file_rdata;
    assign file_rvalid = s_reg.file_rvalid;
    assign avs_readdata = s_reg.av_rdata;
    assign avs_waitrequest = s_reg.av_wait;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    sequence plain_step;
        instr_valid && !branch && !pc_low_wr;
    endsequence
    sequence ind_read_zero;
        file_rd && file_addr == FA_INDIRECT && s_reg.ptr[4:0] == 5'h00;
    endsequence
    sequence ind_read_ram;
        file_rd && file_addr == FA_INDIRECT && rd_tgt == TGT_RAM;
    endsequence

    chk_pc_increment: assert property (
        plain_step |=> pc == 10'($past(pc) + 10'h001))
        else $error("pc did not advance by one");
    chk_pc_wrap: assert property (
        plain_step and pc == PC_RESET |=> pc == 10'h000)
        else $error("pc did not wrap to zero");
    chk_jump_target: assert property (
        instr_valid && op_jump |=> pc[8:0] == $past(instr_word[8:0])
            && pc[9] == $past(s_reg.status[PAGE_BIT]))
        else $error("jump target wrong");
    chk_call_target: assert property (
        stk_push |=> pc[8] == 1'b0 && pc[7:0] == $past(instr_word[7:0])
            && pc[9] == $past(s_reg.status[PAGE_BIT]))
        else $error("call target wrong");
    chk_pcl_write: assert property (
        pc_low_wr && !branch |=> pc == {$past(page), 1'b0,
            $past(file_wdata)})
        else $error("latch write did not load pc");
    // Case equality: level two holds no value before the second call
    chk_call_push: assert property (
        stk_push |=> stk_top == {2'b00, 10'($past(pc) + 10'h001)}
            && stk_second === $past(stk_top))
        else $error("call push wrong");
    chk_ret_pop: assert property (
        stk_pop |=> pc == $past(stk_top[9:0]) && w_load
            && w_data == $past(instr_word[7:0]) ##1 !w_load)
        else $error("return pop wrong");
    chk_level_two: assert property (
        stk_pop |=> stk_top == $past(stk_second)
            && stk_second == $past(stk_second))
        else $error("level two not kept on return");
    chk_ind_zero: assert property (
        ind_read_zero |=> !ram_rd ##1 file_rvalid && file_rdata == 8'h00)
        else $error("indirect zero read not 00h");
    chk_ind_addr: assert property (
        ind_read_ram |=> ram_rd && ram_addr == $past({s_reg.ptr[5],
            s_reg.ptr[4:0]}))
        else $error("indirect address wrong");
    chk_ind_wvoid: assert property (
        file_wr && file_addr == FA_INDIRECT && s_reg.ptr[4:0] == 5'h00
            |=> !ram_wr)
        else $error("indirect self write stored");
    chk_ptr_ones: assert property (
        s_reg.ptr[7:6] == 2'b11)
        else $error("pointer top bits not ones");
    chk_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
            ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

endmodule : pcsia_core

// *** sim/pcsia_ram_model.sv ***
module pcsia_ram_model
    import pcsia_pkg::*;
(
    input wire logic clock,
    input wire logic [5:0] ram_addr,
    input wire logic ram_rd,
    input wire logic ram_wr,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] mem [64];
    logic [7:0] held_reg;
    logic hold_reg;

    initial
    begin
        for (int i = 0; i < 64; i++)
            mem[i] = 8'(i) ^ 8'h3c;
        held_reg = 8'h00;
        hold_reg = 1'b0;
    end

    // ----------------------------------------------------------------
    // Data file storage, two banks of 32 bytes
    // ----------------------------------------------------------------
    always @(posedge clock)
    begin
        if (ram_wr)
            mem[ram_addr] <= ram_wdata;
        hold_reg <= ram_rd;
        if (ram_rd)
            held_reg <= mem[ram_addr];
    end

    // Data valid during the read and one cycle on; then deliberately wrong
    // so a late sample cannot pass by luck
    always_comb
    begin
        if (ram_rd)
            ram_rdata = mem[ram_addr];
        else if (hold_reg)
            ram_rdata = held_reg;
        else
            ram_rdata = ~held_reg;
    end
endmodule : pcsia_ram_model

// *** sim/pc_stack_indirect_addressing_tb.sv ***
module pc_stack_indirect_addressing_tb
    import pcsia_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------------------------------
    // Signals and reference state
    // ----------------------------------------------------------------
    logic clock, arst_n, instr_valid, op_jump, op_call;
    logic return_with_literal_op;
    logic [11:0] instr_word;
    logic file_rd, file_wr, w_load, ram_rd, ram_wr, file_rvalid;
    logic [4:0] file_addr;
    logic [7:0] file_wdata, ram_rdata, w_data, ram_wdata, file_rdata;
    logic [9:0] pc;
    logic [5:0] ram_addr;
    logic [2:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, q;
    int error_cnt, checked, seed, n_wr, n;
    int m_pc, m_s1, m_s2, m_stat, m_ptr;
    int mem [64];

    pcsia_core pcsia_core_inst (.clock, .arst_n, .instr_valid, .op_jump,
        .op_call, .return_with_literal_op, .instr_word, .file_rd, .file_wr,
        .file_addr, .file_wdata, .ram_rdata, .pc, .w_load, .w_data,
        .ram_addr, .ram_rd, .ram_wr, .ram_wdata, .file_rdata, .file_rvalid,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest);
    pcsia_ram_model pcsia_ram_model_inst (.clock, .ram_addr, .ram_rd,
        .ram_wr, .ram_wdata, .ram_rdata);

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock)
        if (ram_wr === 1'b1)
            n_wr++;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // Bank bit and offset reached by a data file address
    function automatic int eff(input int a);
        return (a == 0) ? (m_ptr & 63) : a;
    endfunction : eff

    task automatic avs(input logic wr, input logic [2:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clock);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (avs_waitrequest !== 1'b0 && k < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            error_cnt++;
            close_out();
        end
        if (wr && a == 3)
            m_stat = d & 8'hbf;
        if (wr && a == 4)
            m_ptr = d[7:0] | 8'hc0;
        if (!wr)
            chk("avs_readdata", q, a == 3 ? m_stat : a == 4 ? m_ptr :
                a == 5 ? m_pc : a == 6 ? m_s1 : a == 7 ? m_s2 : 0);
    endtask : avs

    // Kind 0 plain, 1 jump, 2 call, 3 return with literal
    task automatic exec(input int k, input logic [11:0] w);
        int pg;
        @(posedge clock);
        instr_valid <= 1'b1;
        op_jump <= (k == 1);
        op_call <= (k == 2);
        return_with_literal_op <= (k == 3);
        instr_word <= w;
        @(posedge clock);
        instr_valid <= 1'b0;
        pg = (m_stat & 32) << 4;
        if (k == 2)
        begin
            m_s2 = m_s1;
            m_s1 = (m_pc + 1) % 1024;
        end
        if (k == 1)
            m_pc = pg + w[8:0];
        else if (k == 2)
            m_pc = pg + w[7:0];
        else if (k == 3)
            m_pc = m_s1 % 1024;
        else
            m_pc = (m_pc + 1) % 1024;
        if (k == 3)
            m_s1 = m_s2;
        @(negedge clock);
        chk("pc", pc, m_pc);
        chk("w_load", w_load, k == 3);
        if (k == 3)
            chk("w_data", w_data, w[7:0]);
    endtask : exec

    task automatic fwr(input logic [4:0] a, input logic [7:0] d);
        int e;
        @(posedge clock);
        file_wr <= 1'b1;
        file_addr <= a;
        file_wdata <= d;
        @(posedge clock);
        file_wr <= 1'b0;
        e = eff(a);
        if ((e & 31) == 2)
            m_pc = ((m_stat & 32) << 4) + d;
        else if ((e & 31) == 3)
            m_stat = d & 8'hbf;
        else if ((e & 31) == 4)
            m_ptr = d | 8'hc0;
        else if ((e & 31) != 0)
            mem[e] = d;
        @(negedge clock);
        chk("pc", pc, m_pc);
    endtask : fwr

    task automatic frd(input logic [4:0] a);
        int e, k;
        k = 0;
        @(posedge clock);
        file_rd <= 1'b1;
        file_addr <= a;
        @(posedge clock);
        file_rd <= 1'b0;
        while (file_rvalid !== 1'b1 && k < 8)
        begin
            @(posedge clock);
            k++;
        end
        if (k >= 8)
        begin
            error_cnt++;
            close_out();
        end
        e = eff(a);
        chk("file_rdata", file_rdata, (e & 31) == 0 ? 0 : (e & 31) == 2 ?
            m_pc & 255 : (e & 31) == 3 ? m_stat : (e & 31) == 4 ? m_ptr :
            mem[e]);
    endtask : frd

    task automatic rst();
        @(posedge clock);
        arst_n <= 1'b0;
        repeat (3) @(posedge clock);
        arst_n <= 1'b1;
        m_pc = 1023;
        m_stat = 8'h18;
        m_ptr = 8'hc0;
    endtask : rst

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        #5000000;
        error_cnt++;
        close_out();
    end

    initial
    begin
        {arst_n, instr_valid, op_jump, op_call, instr_word} = '0;
        return_with_literal_op = 1'b0;
        {file_rd, file_wr, file_addr, file_wdata} = '0;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        {error_cnt, checked, n_wr} = '0;
        seed = 32'h547e;
        for (int i = 0; i < 64; i++)
            mem[i] = i ^ 8'h3c;
        rst();
        for (int a = 0; a < 6; a++)
            avs(1'b0, 3'(a), 0);
        exec(0, 12'h000);
        repeat (3) exec(0, 12'($random(seed)));
        frd(5'h02);
        for (int i = 0; i < 6; i++)
        begin
            avs(1'b1, REG_STATUS, $random(seed) & 32'h27);
            exec(1, 12'($random(seed)));
        end
        exec(2, 12'h0a5);
        exec(2, 12'h013);
        exec(2, 12'h0c6);
        avs(1'b1, REG_STK1, 32'h155);
        avs(1'b1, REG_PC, 32'h0aa);
        for (int a = 5; a < 8; a++)
            avs(1'b0, 3'(a), 0);
        repeat (3) exec(3, 12'($random(seed)));
        for (int a = 3; a < 8; a++)
            avs(1'b0, 3'(a), 0);
        fwr(5'h02, 8'($random(seed)));
        fwr(5'h04, 8'h02);
        fwr(5'h00, 8'($random(seed)));
        fwr(5'h07, 8'h10);
        fwr(5'h08, 8'h0a);
        fwr(5'h04, 8'h07);
        frd(5'h00);
        fwr(5'h04, 8'h08);
        frd(5'h00);
        fwr(5'h04, 8'h27);
        fwr(5'h00, 8'($random(seed)));
        frd(5'h00);
        frd(5'h07);
        frd(5'h04);
        for (int i = 0; i < 8; i++)
        begin
            fwr(5'h04, 8'($random(seed)));
            fwr(5'h00, 8'($random(seed)));
            frd(5'h00);
        end
        fwr(5'h04, 8'h00);
        frd(5'h00);
        n = n_wr;
        fwr(5'h00, 8'h77);
        @(negedge clock);
        chk("ram_wr count", n_wr, n);
        avs(1'b1, REG_STATUS, 32'h20);
        exec(2, 12'h044);
        rst();
        avs(1'b0, REG_STK1, 0);
        avs(1'b0, REG_STK2, 0);
        avs(1'b0, REG_STATUS, 0);
        exec(0, 12'h000);
        exec(1, 12'h1ff);
        close_out();
    end
endmodule : pc_stack_indirect_addressing_tb
